// [logic/ssc_ctrl.sv]
// Stand-alone conversion control with parallel/serial three-state outputs.
// Assumes pin inputs synchronous to clock and an analog core giving adc_code.
//
// What this block does
// - Stand-alone operation works in both parallel and serial output modes.
// - The data output buffers are enabled while chip select and the read strobe are both low.
// - A read strobe that falls before the write strobe shows the previous result while settling, until the write strobe rises.
// - With channel-select enable low, a new conversion begins at the rising edge of the write strobe.
// - At conversion end the busy flag drops and the new result is loaded into the output buffers.
// - With channel-select enable high, a write strobe that falls before the read strobe keeps the outputs high impedance until the result is ready.
// - With channel-select enable high the settle flag rises on the falling write strobe, selecting the channel.
// - The channel address is latched on the falling write strobe.
// - Conversion starts when the settle flag falls after the settling period.
// - The busy flag is high while converting and low at the end of conversion.
`default_nettype none
module ssc_ctrl (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Converter pins
  input  wire ssc_pkg::ssc_pins_t          pins,
  output logic [ssc_pkg::DATA_W-1:0]       data_out,
  output logic [ssc_pkg::DATA_W-1:0]       data_oe,
  output logic                             settle_flag,
  output logic                             conversion_busy_flag,
  // Analog core
  input  wire logic [ssc_pkg::DATA_W-1:0]  adc_code,
  output logic [ssc_pkg::CHAN_W-1:0]       mux_channel,
  // Avalon-MM slave
  input  wire ssc_pkg::ssc_avs_req_t       avs_req,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Interrupt
  output logic                             irq
);
  import ssc_pkg::*;

  ssc_state_t                state_ff;
  logic [CNT_W-1:0]          cnt_ff;
  logic                      wr_prev_ff;
  logic                      rd_prev_ff;
  logic                      sdc_prev_ff;
  logic                      wr_risen_ff;
  logic                      early_read_ff;
  logic                      settle_ff;
  logic                      busy_ff;
  logic [CHAN_W-1:0]         chan_ff;
  logic [DATA_W-1:0]         result_ff;
  logic [SER_BITS-1:0]       shift_ff;
  logic [DATA_W-1:0]         dout_ff;
  logic [DATA_W-1:0]         doe_ff;
  logic                      enable_ff;
  logic [IRQ_W-1:0]          irq_stat_ff;
  logic [IRQ_W-1:0]          irq_en_ff;
  logic                      irq_ff;
  logic                      wait_ff;
  logic [31:0]               rdata_ff;

  logic                      wr_fall;
  logic                      wr_rise;
  logic                      sdc_fall;
  logic                      rd_fall;
  logic                      done_ev;
  logic                      settled_ev;
  logic                      bus_wr;
  logic                      bus_hit;
  logic [DATA_W-1:0]         nxt_dout;
  logic [DATA_W-1:0]         nxt_doe;
  logic [31:0]               nxt_rdata;

  assign wr_fall  = !pins.cs_n && wr_prev_ff && !pins.wr_n;
  assign wr_rise  = !pins.cs_n && !wr_prev_ff && pins.wr_n;
  assign rd_fall  = rd_prev_ff && !pins.rd_n;
  assign sdc_fall = sdc_prev_ff && !pins.sdc;
  assign done_ev  = (state_ff == SSC_CONVERT) && (cnt_ff == CNT_W'(CONV_CYCLES - 1));
  assign settled_ev = (state_ff == SSC_SETTLE) && (cnt_ff >= CNT_W'(SETTLE_CYCLES - 1))
                      && (wr_risen_ff || wr_rise);
  assign bus_hit  = (avs_req.read || avs_req.write) && !wait_ff;
  assign bus_wr   = bus_hit && avs_req.write;

  // Strobe history
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_prev_ff  <= 1'b1;
      rd_prev_ff  <= 1'b1;
      sdc_prev_ff <= 1'b1;
    end else begin
      wr_prev_ff  <= pins.wr_n;
      rd_prev_ff  <= pins.rd_n;
      sdc_prev_ff <= pins.sdc;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff    <= SSC_IDLE;
      cnt_ff      <= '0;
      settle_ff   <= 1'b0;
      busy_ff     <= 1'b0;
      wr_risen_ff <= 1'b0;
      chan_ff     <= '0;
    end else begin
      case (state_ff)
        SSC_IDLE: begin
          cnt_ff      <= '0;
          wr_risen_ff <= 1'b0;
          if (enable_ff && wr_fall) begin
            chan_ff <= pins.address;
            if (pins.channel_select_enable) begin
              settle_ff <= 1'b1;
              state_ff  <= SSC_SETTLE;
            end
          end else if (enable_ff && wr_rise && !pins.channel_select_enable) begin
            busy_ff  <= 1'b1;
            state_ff <= SSC_CONVERT;
          end
        end
        SSC_SETTLE: begin
          if (cnt_ff < CNT_W'(SETTLE_CYCLES - 1)) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
          if (wr_rise) begin
            wr_risen_ff <= 1'b1;
            busy_ff     <= 1'b1;
          end
          if (settled_ev) begin
            settle_ff <= 1'b0;
            cnt_ff    <= '0;
            state_ff  <= SSC_CONVERT;
          end
        end
        SSC_CONVERT: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (done_ev) begin
            busy_ff  <= 1'b0;
            cnt_ff   <= '0;
            state_ff <= SSC_IDLE;
          end
        end
        default: begin
          state_ff <= SSC_IDLE;
        end
      endcase
    end
  end

  // Read-before-write ordering of the current cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      early_read_ff <= 1'b0;
    end else if (wr_fall && state_ff == SSC_IDLE) begin
      early_read_ff <= !pins.rd_n;
    end else if (done_ev) begin
      early_read_ff <= 1'b0;
    end
  end

  // Result buffer and serial shifter
  always_ff @(posedge clock) begin
    if (rst) begin
      result_ff <= RESULT_RST;
      shift_ff  <= RESULT_RST;
    end else if (done_ev) begin
      result_ff <= adc_code;
      shift_ff  <= adc_code;
    end else if (rd_fall) begin
      shift_ff <= result_ff;
    end else if (!pins.rd_n && !pins.serial_parallel_select && sdc_fall) begin
      shift_ff <= {shift_ff[SER_BITS-2:0], 1'b0};
    end
  end

  // Output buffer drive
  always_comb begin
    logic show;
    show = !pins.cs_n && !pins.rd_n;
    if (busy_ff || settle_ff) begin
      show = show && early_read_ff && settle_ff && !busy_ff;
    end
    nxt_dout = '0;
    nxt_doe  = '0;
    if (show) begin
      if (pins.serial_parallel_select) begin
        nxt_dout = result_ff;
        nxt_doe  = '1;
      end else begin
        nxt_dout[DATA_W-1] = shift_ff[SER_BITS-1];
        nxt_doe[DATA_W-1]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dout_ff <= '0;
      doe_ff  <= '0;
    end else begin
      dout_ff <= nxt_dout;
      doe_ff  <= nxt_doe;
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && done_ev) || (i == IRQ_SETTLED_BIT && settled_ev)) begin
          irq_stat_ff[i] <= 1'b1;
        end else if (bus_wr && avs_req.address == OFS_IRQ_CLEAR && avs_req.writedata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // Writable registers
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_ff <= CTRL_ENABLE_RST;
      irq_en_ff <= IRQ_ENABLE_RST;
    end else if (bus_wr) begin
      if (avs_req.address == OFS_CTRL) begin
        enable_ff <= avs_req.writedata[CTRL_ENABLE_BIT];
      end
      if (avs_req.address == OFS_IRQ_ENABLE) begin
        irq_en_ff <= avs_req.writedata[IRQ_W-1:0];
      end
    end
  end

  // Read mux
  always_comb begin
    nxt_rdata = '0;
    case (avs_req.address)
      OFS_CTRL: begin
        nxt_rdata[CTRL_ENABLE_BIT] = enable_ff;
      end
      OFS_STATUS: begin
        nxt_rdata[STAT_SETTLE_BIT] = settle_ff;
        nxt_rdata[STAT_BUSY_BIT]   = busy_ff;
        nxt_rdata[STAT_EARLY_BIT]  = early_read_ff;
        nxt_rdata[STAT_CHAN_LSB +: CHAN_W] = chan_ff;
      end
      OFS_RESULT: begin
        nxt_rdata[DATA_W-1:0] = result_ff;
      end
      OFS_IRQ_STATUS: begin
        nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      end
      OFS_IRQ_ENABLE: begin
        nxt_rdata[IRQ_W-1:0] = irq_en_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // One wait cycle per access
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff <= !((avs_req.read || avs_req.write) && wait_ff);
      if (avs_req.read && wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign data_out             = dout_ff;
  assign data_oe              = doe_ff;
  assign settle_flag          = settle_ff;
  assign conversion_busy_flag = busy_ff;
  assign mux_channel          = chan_ff;
  assign avs_readdata         = rdata_ff;
  assign avs_waitrequest      = wait_ff;
  assign irq                  = irq_ff;
endmodule
`default_nettype wire

// [inc/ssc_pkg.sv]
// Package for the stand-alone conversion control block.
// Assumes a 10 MHz clock and an Avalon-MM register master.
`default_nettype none
package ssc_pkg;
  // Clock and phase times
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int CONV_TIME_NS   = 15000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;
  localparam int DATA_W         = 12;
  localparam int CHAN_W         = 5;
  localparam int SER_BITS       = 12;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL       = 5'h00;
  localparam logic [4:0] OFS_STATUS     = 5'h04;
  localparam logic [4:0] OFS_RESULT     = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFS_IRQ_CLEAR  = 5'h10;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h14;

  // Field positions
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int STAT_SETTLE_BIT  = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_EARLY_BIT   = 2;
  localparam int STAT_CHAN_LSB    = 8;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_SETTLED_BIT  = 1;
  localparam int IRQ_W            = 2;

  // Reset values
  localparam logic             CTRL_ENABLE_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RESULT_RST     = 12'h000;

  // Pin group from the controlling logic
  typedef struct packed {
    logic              cs_n;
    logic              wr_n;
    logic              rd_n;
    logic              channel_select_enable;
    logic              serial_parallel_select;
    logic              sdc;
    logic [CHAN_W-1:0] address;
  } ssc_pins_t;

  // Avalon-MM request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } ssc_avs_req_t;

  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_SETTLE,
    SSC_CONVERT
  } ssc_state_t;
endpackage
`default_nettype wire

// [test/ssc_ctrl_monitor.sv]
// Assertions on the conversion control block ports.
// Assumes one clock domain and a synchronous reset.
`default_nettype none
module ssc_ctrl_monitor (
  // Clock and reset
  input wire logic               clock,
  input wire logic               rst,
  // Watched ports
  input wire ssc_pkg::ssc_pins_t pins,
  input wire logic [11:0]        data_out,
  input wire logic [11:0]        data_oe,
  input wire logic               settle_flag,
  input wire logic               conversion_busy_flag,
  input wire logic [11:0]        adc_code,
  input wire logic [4:0]         mux_channel
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;
  logic [7:0] cnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Length of the current settle phase
  always_ff @(posedge clock) begin
    if (rst)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= settle_flag ? cnt_ff + 8'h01 : 8'h00;
  end
  sequence s_start;
    $fell(pins.wr_n) && !pins.cs_n && pins.channel_select_enable && !settle_flag
      && !conversion_busy_flag;
  endsequence
  AST_OE_RD: assert property (|data_oe |-> !$past(pins.rd_n))
    else $error("outputs driven without read strobe");
  AST_BUSY_HIZ: assert property (conversion_busy_flag[*3] |-> data_oe == 12'h000)
    else $error("outputs driven while converting");
  AST_SETTLE_UP: assert property (s_start |-> ##[1:2] settle_flag)
    else $error("settle flag did not rise");
  AST_CHAN: assert property (s_start |-> ##2 mux_channel == $past(pins.address, 2))
    else $error("channel not latched");
  AST_BUSY_UP: assert property ($rose(pins.wr_n) && settle_flag |-> ##[1:2] conversion_busy_flag)
    else $error("busy did not rise");
  AST_SETTLE_LEN: assert property ($fell(settle_flag) |-> cnt_ff >= 8'h64 && $past(pins.wr_n))
    else $error("settle phase too short");
  AST_CONV_LEN: assert property ($fell(settle_flag) |-> ##[148:152] $fell(conversion_busy_flag))
    else $error("conversion length wrong");
  AST_LOAD: assert property ($fell(conversion_busy_flag) && !pins.rd_n && pins.serial_parallel_select
    |-> ##[1:2] data_oe == 12'hFFF && data_out == adc_code)
    else $error("result not loaded");
  AST_SERIAL: assert property (!$past(pins.serial_parallel_select) |-> data_oe[10:0] == 11'h000)
    else $error("serial mode drives parallel bits");
  cover property (s_start);
  cover property ($fell(conversion_busy_flag) && !pins.rd_n);
  cover property ($fell(settle_flag) && !pins.rd_n);
endmodule
bind ssc_ctrl ssc_ctrl_monitor u_mon (.clock(clock), .rst(rst), .pins(pins),
  .data_out(data_out), .data_oe(data_oe), .settle_flag(settle_flag),
  .conversion_busy_flag(conversion_busy_flag), .adc_code(adc_code), .mux_channel(mux_channel));
`default_nettype wire

// [test/ssc_host_model.sv]
// Host logic driving the strobes in stand-alone operation.
// Assumes the bench pulses go and raises rd_off after each result.
`default_nettype none
module ssc_host_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       go,
  input  wire logic       rd_first,
  input  wire logic [7:0] hold,
  input  wire logic       rd_off,
  // Strobes
  output logic            cs_n,
  output logic            cse,
  output logic            wr_n,
  output logic            rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;
  logic       wr_n_ff;
  logic       rd_n_ff;
  assign cs_n = 1'b0;
  assign cse  = 1'b1;
  assign wr_n = wr_n_ff; // Single device, no pair sync gate
  assign rd_n = rd_n_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      cnt_ff  <= 8'h00;
    end else begin
      if (go) begin
        rd_n_ff <= !rd_first;
        cnt_ff  <= 8'h01;
      end else if (cnt_ff == 8'h01) begin
        wr_n_ff <= 1'b0;
        cnt_ff  <= 8'h02;
      end else if (cnt_ff == hold) begin
        wr_n_ff <= 1'b1;
        cnt_ff  <= 8'h00;
      end else if (cnt_ff != 8'h00) begin
        rd_n_ff <= rd_n_ff & rd_first;
        cnt_ff  <= cnt_ff + 8'h01;
      end
      if (rd_off)
        rd_n_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [test/standalone_conversion_control_test.sv]
// Self-checking bench for the stand-alone conversion control.
// Assumes the host model, the bound monitor and ssc_pkg.
`default_nettype none
module standalone_conversion_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;
  logic         clock, rst, go, rd_first, rd_off, sps, sdc, cs_n, cse, wr_n, rd_n;
  logic         set, bsy, irq, wq;
  logic [7:0]   hold;
  logic [4:0]   addr, mux;
  logic [11:0]  code, last, dout, doe;
  logic [31:0]  q, seed, rdata;
  ssc_avs_req_t req;
  ssc_pins_t    pins;
  int           num_errors, n_compared;
  assign pins = '{cs_n, wr_n, rd_n, cse, sps, sdc, addr};
  ssc_host_model host (.clock(clock), .rst(rst), .go(go), .rd_first(rd_first), .hold(hold),
    .rd_off(rd_off), .cs_n(cs_n), .cse(cse), .wr_n(wr_n), .rd_n(rd_n));
  ssc_ctrl dut (.clock(clock), .rst(rst), .pins(pins), .data_out(dout), .data_oe(doe),
    .settle_flag(set), .conversion_busy_flag(bsy), .adc_code(code), .mux_channel(mux),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wq), .irq(irq));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 1000 && bsy !== v; i++)
      @(posedge clock);
    if (i == 1000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    req <= '{!w, w, a, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (wq === 1'b0)
        break;
    end
    q = rdata;
    req <= '0;
    @(posedge clock);
    if (i == 50) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rdc(input string n, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic conv(input logic rf, input logic par);
    logic [31:0] r;
    logic [11:0] m;
    int          i;
    r = xs();
    m = par ? 12'hFFF : 12'h800;
    code <= r[11:0];
    addr <= r[16:12];
    hold <= {1'b0, r[23:17]} + 8'h0A;
    sps <= par;
    rd_first <= rf;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (6) @(posedge clock);
    chk("oe in settle", rf ? m : 12'h000, doe);
    chk("settle flag", 32'h1, set);
    if (rf)
      chk("previous data", last & m, dout & m);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (3) @(posedge clock);
    chk("channel", addr, mux);
    chk("oe after end", m, doe);
    if (par)
      chk("data", code, dout);
    for (i = 11; i >= 0 && !par; i--) begin
      chk("serial bit", code[i], dout[11]);
      sdc <= 1'b0;
      repeat (2) @(posedge clock);
      sdc <= 1'b1;
      repeat (2) @(posedge clock);
    end
    last = code;
    rd_off <= 1'b1;
    @(posedge clock);
    rd_off <= 1'b0;
    @(posedge clock);
    $display("conversion test done");
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
  initial begin
    int          k;
    logic [31:0] r;
    seed = 32'h5A;
    rst = 1'b1;
    {go, rd_first, rd_off, sps, sdc} = 5'h03;
    {hold, addr, code, last, req} = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc("ctrl", OFS_CTRL, {31'h0, CTRL_ENABLE_RST});
    rdc("irq enable", OFS_IRQ_ENABLE, {30'h0, IRQ_ENABLE_RST});
    rdc("unmapped", 5'h1C, 32'h0);
    for (k = 0; k < 8; k++) begin
      r = xs();
      conv(k < 4 ? k[0] : r[0], k < 4 ? k[1] : r[1]);
    end
    chk("irq masked", 32'h0, irq);
    rdc("result", OFS_RESULT, {20'h0, last});
    bus(1'b1, OFS_RESULT, 32'hFFF);
    rdc("result kept", OFS_RESULT, {20'h0, last});
    bus(1'b1, OFS_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge clock);
    chk("irq raised", 32'h1, irq);
    rdc("irq status", OFS_IRQ_STATUS, 32'h3);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, irq);
    rdc("status", OFS_STATUS, {19'h0, addr, 8'h00});
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("oe after reset", 32'h0, doe);
    rdc("result after reset", OFS_RESULT, {20'h0, RESULT_RST});
    $display("register test done");
    end_of_test();
  end
endmodule
`default_nettype wire
